// ---- include/anlsl_defs.svh ----
// anlsl_defs.svh - constants for the link establishment and status led block
// assumes a 20 MHz system clock; times are converted to cycles here
`ifndef ANLSL_DEFS_SVH
`define ANLSL_DEFS_SVH

// ************************
// ability field bit positions
// ************************
`define ANLSL_AB_10HD       0
`define ANLSL_AB_10FD       1
`define ANLSL_AB_100HD      2
`define ANLSL_AB_100FD      3
`define ANLSL_AB_T4         4
`define ANLSL_AB_PAUSE      5
`define ANLSL_LOCAL_ABILITY 8'h0F

// ************************
// code word layout: ability in [12:5], acknowledge at 14
// ************************
`define ANLSL_CW_ABIL_LSB   5
`define ANLSL_CW_ACK        14
`define ANLSL_CW_SELECTOR   16'h0001

// ************************
// handshake counts
// ************************
`define ANLSL_MATCH_COUNT   3
`define ANLSL_ACK_SEND_MIN  6
`define ANLSL_ACK_SEND_MAX  8

// ************************
// timing: clock rate and hold-off interval
// ************************
`define ANLSL_CLK_HZ        20000000
`define ANLSL_HOLDOFF_MS    1500
`define ANLSL_HOLDOFF_CYC   ((`ANLSL_HOLDOFF_MS * `ANLSL_CLK_HZ) / 1000)
`define ANLSL_CW_GAP_US     16
`define ANLSL_CW_GAP_CYC    ((`ANLSL_CW_GAP_US * `ANLSL_CLK_HZ) / 1000000)

`endif

// ---- include/anlsl_pkg.sv ----
// anlsl_pkg.sv - types for the link establishment and status led block
// assumes nothing beyond the defs header
package anlsl_pkg;

   // ************************
   // negotiation states
   // ************************
   typedef enum logic [2:0]
   {
      ST_HOLDOFF  = 3'b000,
      ST_DETECT   = 3'b001,
      ST_ACK_TX   = 3'b010,
      ST_ACK_DONE = 3'b011,
      ST_LINK_UP  = 3'b100
   } anlsl_state_t;

   // resolved technology
   typedef enum logic [2:0]
   {
      TECH_NONE   = 3'b000,
      TECH_10HD   = 3'b001,
      TECH_10FD   = 3'b010,
      TECH_100HD  = 3'b011,
      TECH_T4     = 3'b100,
      TECH_100FD  = 3'b101
   } anlsl_tech_t;

endpackage

// ---- include/anlsl_led_if.sv ----
// anlsl_led_if.sv - link state handed from negotiation to the led driver
// assumes both ends share CLOCK_IN
`timescale 1ns/1ns
interface anlsl_led_if;
   logic link_up;
   logic speed_100;
   logic full_duplex;

   modport src (output link_up, output speed_100, output full_duplex);
   modport dst (input link_up, input speed_100, input full_duplex);
endinterface

// ---- logic/anlsl_leds.sv ----
// anlsl_leds.sv - the four active-low status leds
// assumes link state arrives registered from the negotiation logic
`timescale 1ns/1ns
`include "anlsl_defs.svh"
module anlsl_leds
(
   // clock and reset
   input  wire logic  clk_in,
   input  wire logic  rst_n_in,
   // link state
   anlsl_led_if.dst   st,
   // activity and mode
   input  wire logic  tx_active_in,
   input  wire logic  rx_active_in,
   input  wire logic  repeater_mode_in,
   input  wire logic  loopback_in,
   input  wire logic  duplex_led_en_in,
   input  wire logic  forced_in,
   input  wire logic  forced_100_in,
   // leds, active low
   output logic       link_led_n_out,
   output logic       act_led_n_out,
   output logic       speed_led_n_out,
   output logic       duplex_indicator_n_out
);

   typedef struct packed
   {
      logic link_n;
      logic act_n;
      logic speed_n;
      logic duplex_indicator_n;
   } anlsl_led_state_t;

   anlsl_led_state_t r;
   anlsl_led_state_t next_r;

   // led decode
   always_comb
   begin
      next_r = r;
      next_r.link_n = !st.link_up;
      if (loopback_in)
         next_r.act_n = 1'b1;
      else if (repeater_mode_in)
         next_r.act_n = !rx_active_in;
      else
         next_r.act_n = !(rx_active_in || tx_active_in);
      if (forced_in)
         next_r.speed_n = !forced_100_in;
      else if (st.link_up)
         next_r.speed_n = !st.speed_100;
      next_r.duplex_indicator_n = !(duplex_led_en_in && st.link_up && st.full_duplex);
   end

   // led state register, all dark at reset
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         r <= '1;
      else
         r <= next_r;
   end

   assign link_led_n_out         = r.link_n;
   assign act_led_n_out          = r.act_n;
   assign speed_led_n_out        = r.speed_n;
   assign duplex_indicator_n_out = r.duplex_indicator_n;

endmodule

// ---- logic/anlsl_top.sv ----
// anlsl_top.sv - link establishment: hold-off, negotiation, parallel detect
// assumes a line front end that decodes received code words and link pulses
// Behaviour
// - negotiation runs only while the enable control bit is set
// - if negotiation fails, clear enable and use parallel detection
// - hardware reset or renegotiate command restarts link establishment
// - ability bits: 10HD,10FD,100HD,100FD,T4,pause; 6 and 7 reserved
// - advertise ability bits zero to three set
// - priority: 100FD, T4, 100HD, 10FD, 10HD
// - set acknowledge only after three matching partner code words
// - after three matching acked words send six to eight more, resolve
// - capture partner code word for software to read
// - on reset, link loss or command, hold long silent interval first
// - watch for both code word bursts and plain link pulses
// - after link is up, stop bursts, use normal link pulses
// - link led high until valid link, then low
// - adapter mode: activity led on for transmit or receive; the logic holds it dark while loopback is set
// - repeater mode: activity led on for receive only; the logic holds it dark while loopback is set
// - speed led on for 100, off for 10, holds on failure
// - forced speed sets speed led regardless of link
// - duplex indicator shows full duplex link when enabled
// - hardware reset or the soft reset bit reset the logic; soft reset leaves the led register and transmit word alone
`timescale 1ns/1ns
`include "anlsl_defs.svh"
module anlsl_top
#(
   parameter int HOLDOFF_CYC  = `ANLSL_HOLDOFF_CYC,
   parameter int ACK_SEND_CNT = `ANLSL_ACK_SEND_MIN
)
(
   // clock and reset
   input  wire logic        CLOCK_IN,
   input  wire logic        RST_N_IN,
   // control bits from the management register port
   input  wire logic        NEG_ENABLE_SET_IN,
   input  wire logic        RENEGOTIATE_IN,
   input  wire logic        SOFT_RESET_IN,
   input  wire logic        FORCE_SPEED_IN,
   input  wire logic        FORCE_100_IN,
   input  wire logic        FORCE_FULL_IN,
   input  wire logic        REPEATER_MODE_IN,
   input  wire logic        LOOPBACK_IN,
   input  wire logic        DUPLEX_LED_EN_IN,
   // line receive side
   input  wire logic        RX_CW_VALID_IN,
   input  wire logic [15:0] RX_CW_IN,
   input  wire logic        RX_LINK_PULSE_IN,
   input  wire logic        RX_100_IDLE_IN,
   input  wire logic        LINK_OK_IN,
   input  wire logic        TX_ACTIVE_IN,
   input  wire logic        RX_ACTIVE_IN,
   // line transmit side
   output logic             TX_CW_SEND_OUT,
   output logic [15:0]      TX_CW_OUT,
   output logic             TX_BURST_EN_OUT,
   output logic             TX_NATIVE_PULSE_EN_OUT,
   // status bits
   output logic             NEG_ENABLE_OUT,
   output logic [15:0]      PARTNER_CW_OUT,
   output logic             NEG_COMPLETE_OUT,
   output logic             PARALLEL_DET_OUT,
   output logic             LINK_UP_OUT,
   output logic             SPEED_100_OUT,
   output logic             FULL_DUPLEX_OUT,
   // leds, active low
   output logic             LINK_LED_N_OUT,
   output logic             ACT_LED_N_OUT,
   output logic             SPEED_LED_N_OUT,
   output logic             DUPLEX_INDICATOR_N_OUT
);

   // ************************
   // resolution function
   // ************************
   // fixed priority order
   function automatic anlsl_pkg::anlsl_tech_t resolve(input logic [7:0] common);
      anlsl_pkg::anlsl_tech_t t;
      t = anlsl_pkg::TECH_NONE;
      if (common[`ANLSL_AB_100FD])
         t = anlsl_pkg::TECH_100FD;
      else if (common[`ANLSL_AB_T4])
         t = anlsl_pkg::TECH_T4;
      else if (common[`ANLSL_AB_100HD])
         t = anlsl_pkg::TECH_100HD;
      else if (common[`ANLSL_AB_10FD])
         t = anlsl_pkg::TECH_10FD;
      else if (common[`ANLSL_AB_10HD])
         t = anlsl_pkg::TECH_10HD;
      return t;
   endfunction

   // ************************
   // state
   // ************************
   typedef struct packed
   {
      anlsl_pkg::anlsl_state_t st;
      logic [31:0]             timer;
      logic [1:0]              match_cnt;
      logic [3:0]              sent_cnt;
      logic [15:0]             last_cw;
      logic [15:0]             partner_cw;
      logic                    ack;
      logic                    neg_en;
      logic                    parallel;
      logic                    complete;
      logic                    link_up;
      logic                    speed_100;
      logic                    full;
      logic                    cw_send;
   } anlsl_core_t;

   anlsl_core_t r;
   anlsl_core_t next_r;
   logic [15:0] local_cw;
   logic        restart;
   anlsl_pkg::anlsl_tech_t tech;

   // advertise bits zero to three
   // built from the next ack, so a word launched with it carries it
   assign local_cw = `ANLSL_CW_SELECTOR
                   | {3'h0, `ANLSL_LOCAL_ABILITY, 5'h00}
                   | (16'(next_r.ack) << `ANLSL_CW_ACK);
   assign tech = resolve(`ANLSL_LOCAL_ABILITY & r.partner_cw[12:5]);
   assign restart = RENEGOTIATE_IN || (r.st == anlsl_pkg::ST_LINK_UP && !LINK_OK_IN);

   // ************************
   // negotiation sequencer
   // ************************
   always_comb
   begin
      next_r = r;
      next_r.cw_send = 1'b0;
      if (NEG_ENABLE_SET_IN)
         next_r.neg_en = 1'b1;
      // timer count-down: hold-off interval, then code word pacing while bursts run
      if (r.timer != 32'h0)
         next_r.timer = r.timer - 32'h1;
      if (restart)
      begin
         next_r.st       = anlsl_pkg::ST_HOLDOFF;
         next_r.timer    = 32'(HOLDOFF_CYC);
         next_r.link_up  = 1'b0;
         next_r.ack      = 1'b0;
         next_r.complete = 1'b0;
         next_r.parallel = 1'b0;
         next_r.match_cnt = 2'h0;
      end
      else
      begin
         case (r.st)
            anlsl_pkg::ST_HOLDOFF:
            begin
               if (r.timer == 32'h0)
               begin
                  next_r.st = anlsl_pkg::ST_DETECT;
                  next_r.match_cnt = 2'h0;
               end
            end
            anlsl_pkg::ST_DETECT, anlsl_pkg::ST_ACK_TX:
            begin
               if (r.neg_en && r.timer == 32'h0)
               begin
                  next_r.cw_send = 1'b1;
                  next_r.timer   = 32'(`ANLSL_CW_GAP_CYC);
               end
               if (RX_CW_VALID_IN && r.neg_en)
               begin
                  next_r.partner_cw = RX_CW_IN;
                  next_r.last_cw    = RX_CW_IN;
                  if (RX_CW_IN != r.last_cw)
                     next_r.match_cnt = 2'h1;
                  else if (r.match_cnt != 2'(`ANLSL_MATCH_COUNT))
                     next_r.match_cnt = r.match_cnt + 2'h1;
                  if (r.st == anlsl_pkg::ST_DETECT && RX_CW_IN == r.last_cw
                      && r.match_cnt == 2'(`ANLSL_MATCH_COUNT - 1))
                  begin
                     next_r.ack = 1'b1;
                     next_r.st  = anlsl_pkg::ST_ACK_TX;
                     next_r.match_cnt = 2'h0;
                  end
                  if (r.st == anlsl_pkg::ST_ACK_TX && RX_CW_IN[`ANLSL_CW_ACK]
                      && RX_CW_IN == r.last_cw
                      && r.match_cnt == 2'(`ANLSL_MATCH_COUNT - 1))
                  begin
                     next_r.st = anlsl_pkg::ST_ACK_DONE;
                     next_r.sent_cnt = 4'h0;
                  end
               end
               // partner sends plain pulses: parallel detect
               else if (r.st == anlsl_pkg::ST_DETECT
                        && (RX_LINK_PULSE_IN || RX_100_IDLE_IN))
               begin
                  next_r.neg_en    = 1'b0;
                  next_r.parallel  = 1'b1;
                  next_r.speed_100 = RX_100_IDLE_IN;
                  next_r.full      = 1'b0;
                  next_r.link_up   = 1'b1;
                  next_r.st        = anlsl_pkg::ST_LINK_UP;
               end
            end
            anlsl_pkg::ST_ACK_DONE:
            begin
               if (r.timer == 32'h0)
               begin
                  next_r.cw_send  = 1'b1;
                  next_r.timer    = 32'(`ANLSL_CW_GAP_CYC);
                  next_r.sent_cnt = r.sent_cnt + 4'h1;
               end
               if (r.sent_cnt == 4'(ACK_SEND_CNT))
               begin
                  next_r.complete  = 1'b1;
                  next_r.link_up   = (tech != anlsl_pkg::TECH_NONE);
                  next_r.speed_100 = (tech == anlsl_pkg::TECH_100FD)
                                  || (tech == anlsl_pkg::TECH_100HD)
                                  || (tech == anlsl_pkg::TECH_T4);
                  next_r.full      = (tech == anlsl_pkg::TECH_100FD)
                                  || (tech == anlsl_pkg::TECH_10FD);
                  next_r.st        = anlsl_pkg::ST_LINK_UP;
               end
            end
            anlsl_pkg::ST_LINK_UP:
            begin
               if (FORCE_SPEED_IN)
               begin
                  next_r.speed_100 = FORCE_100_IN;
                  next_r.full      = FORCE_FULL_IN;
               end
            end
            default:
               next_r.st = anlsl_pkg::ST_HOLDOFF;
         endcase
      end
   end

   always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         r          <= '0;
         r.timer    <= 32'(HOLDOFF_CYC);
         r.neg_en   <= 1'b1;
      end
      else if (SOFT_RESET_IN)
      begin
         r          <= '0;
         r.timer    <= 32'(HOLDOFF_CYC);
         r.neg_en   <= 1'b1;
      end
      else
         r <= next_r;
   end

   // ************************
   // outputs and transmit word register
   // ************************
   logic [15:0] tx_cw;

   // word latched when a burst is launched
   always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
         tx_cw <= 16'h0000;
      else if (next_r.cw_send)
         tx_cw <= local_cw;
   end

   assign TX_CW_SEND_OUT         = r.cw_send;
   assign TX_CW_OUT              = tx_cw;
   assign TX_BURST_EN_OUT        = (r.st != anlsl_pkg::ST_HOLDOFF)
                                && (r.st != anlsl_pkg::ST_LINK_UP) && r.neg_en;
   assign TX_NATIVE_PULSE_EN_OUT = r.link_up;
   assign NEG_ENABLE_OUT         = r.neg_en;
   assign PARTNER_CW_OUT         = r.partner_cw;
   assign NEG_COMPLETE_OUT       = r.complete;
   assign PARALLEL_DET_OUT       = r.parallel;
   assign LINK_UP_OUT            = r.link_up;
   assign SPEED_100_OUT          = r.speed_100;
   assign FULL_DUPLEX_OUT        = r.full;

   // ************************
   // status leds
   // ************************
   anlsl_led_if led_st ();
   assign led_st.link_up     = r.link_up;
   assign led_st.speed_100   = r.speed_100;
   assign led_st.full_duplex = r.full;

   anlsl_leds u_leds
   (
      .clk_in                 (CLOCK_IN),
      .rst_n_in               (RST_N_IN),
      .st                     (led_st),
      .tx_active_in           (TX_ACTIVE_IN),
      .rx_active_in           (RX_ACTIVE_IN),
      .repeater_mode_in       (REPEATER_MODE_IN),
      .loopback_in            (LOOPBACK_IN),
      .duplex_led_en_in       (DUPLEX_LED_EN_IN),
      .forced_in              (FORCE_SPEED_IN),
      .forced_100_in          (FORCE_100_IN),
      .link_led_n_out         (LINK_LED_N_OUT),
      .act_led_n_out          (ACT_LED_N_OUT),
      .speed_led_n_out        (SPEED_LED_N_OUT),
      .duplex_indicator_n_out (DUPLEX_INDICATOR_N_OUT)
   );

endmodule

// ---- tb/anlsl_asserts.sv ----
// anlsl_asserts.sv - port timing checks for the link establishment block
// assumes it is bound into anlsl_top and sees only that module's ports
`timescale 1ns/1ns
module anlsl_asserts
#(
   parameter int HOLDOFF_CYC  = 50,
   parameter int ACK_SEND_CNT = 6
)
(
   // clock, reset and controls
   input  wire logic        CLOCK_IN,
   input  wire logic        RST_N_IN,
   input  wire logic        SOFT_RESET_IN,
   input  wire logic        RENEGOTIATE_IN,
   input  wire logic        FORCE_SPEED_IN,
   input  wire logic        FORCE_100_IN,
   input  wire logic        REPEATER_MODE_IN,
   input  wire logic        LOOPBACK_IN,
   input  wire logic        DUPLEX_LED_EN_IN,
   // line side
   input  wire logic        RX_CW_VALID_IN,
   input  wire logic        TX_ACTIVE_IN,
   input  wire logic        RX_ACTIVE_IN,
   input  wire logic        TX_CW_SEND_OUT,
   input  wire logic [15:0] TX_CW_OUT,
   input  wire logic        TX_BURST_EN_OUT,
   input  wire logic        TX_NATIVE_PULSE_EN_OUT,
   // status and leds
   input  wire logic        NEG_ENABLE_OUT,
   input  wire logic        NEG_COMPLETE_OUT,
   input  wire logic        PARALLEL_DET_OUT,
   input  wire logic        LINK_UP_OUT,
   input  wire logic        FULL_DUPLEX_OUT,
   input  wire logic        LINK_LED_N_OUT,
   input  wire logic        ACT_LED_N_OUT,
   input  wire logic        SPEED_LED_N_OUT,
   input  wire logic        DUPLEX_INDICATOR_N_OUT
);
   logic [15:0] hold_cnt;
   logic [7:0]  rx_cnt;
   logic [7:0]  ack_cnt;
   // ************************
   // helper counts since the last reset, soft reset or renegotiate command
   // ************************
   // saturating, so a long link never wraps them into a false alarm
   always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
         {hold_cnt, rx_cnt, ack_cnt} <= '0;
      else if (SOFT_RESET_IN || RENEGOTIATE_IN)
         {hold_cnt, rx_cnt, ack_cnt} <= '0;
      else
      begin
         if (hold_cnt != 16'hFFFF) hold_cnt <= hold_cnt + 16'h1;
         if (RX_CW_VALID_IN && !LINK_UP_OUT && rx_cnt != 8'hFF) rx_cnt <= rx_cnt + 8'h1;
         if (TX_CW_SEND_OUT && TX_CW_OUT[14] && ack_cnt != 8'hFF) ack_cnt <= ack_cnt + 8'h1;
      end
   end
   // ************************
   // assertions
   // ************************
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (!RST_N_IN);
   a_holdoff_silent: assert property (hold_cnt < HOLDOFF_CYC - 1
      |-> !TX_CW_SEND_OUT && !TX_BURST_EN_OUT)
      else $error("code word during hold-off");
   a_advert_word: assert property (TX_CW_SEND_OUT |-> TX_CW_OUT[12:0] == 13'h01E1)
      else $error("advertised word wrong");
   a_ack_three: assert property ($rose(TX_CW_OUT[14]) |-> rx_cnt >= 8'h03)
      else $error("ack set too early");
   a_link_acks: assert property ($rose(LINK_UP_OUT) && NEG_COMPLETE_OUT
      |-> ack_cnt >= ACK_SEND_CNT - 1)
      else $error("link up before ack words");
   a_native_link: assert property (LINK_UP_OUT |-> TX_NATIVE_PULSE_EN_OUT && !TX_BURST_EN_OUT)
      else $error("bursts while link up");
   a_parallel_clear: assert property (PARALLEL_DET_OUT && LINK_UP_OUT |-> !NEG_ENABLE_OUT)
      else $error("enable kept on parallel detect");
   a_link_led: assert property (!$past(SOFT_RESET_IN) |-> LINK_LED_N_OUT == !$past(LINK_UP_OUT))
      else $error("link led wrong");
   a_act_adapter: assert property (!REPEATER_MODE_IN && !LOOPBACK_IN && !SOFT_RESET_IN
      && (TX_ACTIVE_IN || RX_ACTIVE_IN) |=> !ACT_LED_N_OUT)
      else $error("activity led dark");
   a_act_repeater: assert property (REPEATER_MODE_IN && !LOOPBACK_IN && !RX_ACTIVE_IN
      && !SOFT_RESET_IN |=> ACT_LED_N_OUT)
      else $error("activity led lit");
   a_speed_forced: assert property (FORCE_SPEED_IN && !SOFT_RESET_IN
      |=> SPEED_LED_N_OUT == !$past(FORCE_100_IN))
      else $error("forced speed led wrong");
   a_duplex_led: assert property (DUPLEX_LED_EN_IN && LINK_UP_OUT && FULL_DUPLEX_OUT
      && !SOFT_RESET_IN |=> !DUPLEX_INDICATOR_N_OUT)
      else $error("duplex led dark");
   c_neg_done: cover property ($rose(LINK_UP_OUT) && NEG_COMPLETE_OUT);
   c_parallel: cover property ($rose(LINK_UP_OUT) && PARALLEL_DET_OUT);
   c_ack_rise: cover property ($rose(TX_CW_OUT[14]));
endmodule
// checker ports carry the top's port names, so all connect by name
bind anlsl_top anlsl_asserts #(.HOLDOFF_CYC(HOLDOFF_CYC), .ACK_SEND_CNT(ACK_SEND_CNT)) u_asserts
(
   .*
);

// ---- tb/anlsl_partner.sv ----
// anlsl_partner.sv - far-end station on the cable
// assumes the bench sets its mode; it acks after three words from the device
`timescale 1ns/1ns
module anlsl_partner
(
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   // mode: 0 silent, 1 negotiate, 2 10M pulses, 3 100M idle
   input  wire logic [1:0]  mode_in,
   input  wire logic [7:0]  abil_in,
   input  wire logic [9:0]  gap_in,
   input  wire logic        dev_send_in,
   // line toward the device
   output logic             cw_valid_out,
   output logic [15:0]      cw_out,
   output logic             link_pulse_out,
   output logic             idle_100_out
);
   logic [9:0] tick;
   logic [1:0] seen;
   // ************************
   // word and pulse source
   // ************************
   // rising edge and nonblocking, so bench mode changes never race it;
   // between words the data toggles, so a stale word never looks valid
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         {tick, seen, cw_valid_out, link_pulse_out} <= '0;
         cw_out <= 16'hFFFF;
      end
      else
      begin
         tick           <= (tick >= gap_in) ? 10'd0 : tick + 10'd1;
         cw_valid_out   <= (tick == 10'd0) && (mode_in == 2'd1);
         link_pulse_out <= (tick == 10'd0) && (mode_in == 2'd2);
         cw_out <= (tick == 10'd0) ? {1'b0, seen == 2'd3, 1'b0, abil_in, 5'h01} : ~cw_out;
         if (mode_in != 2'd1) seen <= 2'd0;
         else if (dev_send_in && seen != 2'd3) seen <= seen + 2'd1;
      end
   end
   // steady 100M idle while legacy fast mode is chosen
   assign idle_100_out = (mode_in == 2'd3);
endmodule

// ---- tb/autoneg_link_status_leds_bench.sv ----
// autoneg_link_status_leds_bench.sv - self-checking bench for anlsl_top
// assumes a short hold-off parameter and the partner model on the line
`timescale 1ns/1ns
module autoneg_link_status_leds_bench;
   localparam int HOLD = 50;
   logic clk = 0, rst_n = 0, neg_set = 0, reneg = 0, soft_rst = 0;
   logic frc = 0, frc100 = 0, rep = 0, dled = 0, link_ok = 1, tx_act = 0, rx_act = 0;
   logic [1:0] p_mode = 0;
   logic [7:0] p_ab = 0;
   logic [9:0] p_gap = 10'd40;
   logic cw_v, lp, idle, send, burst, native, neg_en, ncomp, pdet, up, spd, fd;
   logic l_led, a_led, s_led, d_led;
   logic [15:0] cw, tx_cw, pcw;
   int err_count = 0, tests_run = 0, cyc = 0;
   // ************************
   // clock, design and far end
   // ************************
   always #25 clk = ~clk;
   anlsl_top #(.HOLDOFF_CYC(HOLD), .ACK_SEND_CNT(6)) DUT
   (
      .CLOCK_IN(clk), .RST_N_IN(rst_n), .NEG_ENABLE_SET_IN(neg_set), .RENEGOTIATE_IN(reneg),
      .SOFT_RESET_IN(soft_rst), .FORCE_SPEED_IN(frc), .FORCE_100_IN(frc100),
      .FORCE_FULL_IN(1'b0), .REPEATER_MODE_IN(rep), .LOOPBACK_IN(1'b0),
      .DUPLEX_LED_EN_IN(dled), .RX_CW_VALID_IN(cw_v), .RX_CW_IN(cw), .RX_LINK_PULSE_IN(lp),
      .RX_100_IDLE_IN(idle), .LINK_OK_IN(link_ok), .TX_ACTIVE_IN(tx_act),
      .RX_ACTIVE_IN(rx_act), .TX_CW_SEND_OUT(send), .TX_CW_OUT(tx_cw),
      .TX_BURST_EN_OUT(burst), .TX_NATIVE_PULSE_EN_OUT(native), .NEG_ENABLE_OUT(neg_en),
      .PARTNER_CW_OUT(pcw), .NEG_COMPLETE_OUT(ncomp), .PARALLEL_DET_OUT(pdet),
      .LINK_UP_OUT(up), .SPEED_100_OUT(spd), .FULL_DUPLEX_OUT(fd), .LINK_LED_N_OUT(l_led),
      .ACT_LED_N_OUT(a_led), .SPEED_LED_N_OUT(s_led), .DUPLEX_INDICATOR_N_OUT(d_led)
   );
   anlsl_partner u_far
   (
      .clk_in(clk), .rst_n_in(rst_n), .mode_in(p_mode), .abil_in(p_ab), .gap_in(p_gap),
      .dev_send_in(send), .cw_valid_out(cw_v), .cw_out(cw), .link_pulse_out(lp),
      .idle_100_out(idle)
   );
   // ************************
   // tasks
   // ************************
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic ticks(input int n);
      repeat (n) @(negedge clk);
   endtask
   // restart with or without setting the enable bit
   task automatic restart(input logic en, input logic [1:0] md);
      p_mode = 2'd0;
      @(negedge clk);
      neg_set = en;
      reneg = 1'b1;
      @(negedge clk);
      neg_set = 1'b0;
      reneg = 1'b0;
      p_mode = md;
   endtask
   // bounded wait for link, then one more cycle for the leds
   task automatic wait_up(input int lim);
      int n;
      n = 0;
      while (up !== 1'b1 && n < lim)
      begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
   endtask
   function automatic logic [2:0] expect_res(input logic [7:0] ab);
      logic [7:0] c;
      c = ab & 8'h0F;
      if (c[3]) return 3'b111;
      else if (c[2]) return 3'b110;
      else if (c[1]) return 3'b101;
      else if (c[0]) return 3'b100;
      return 3'b000;
   endfunction
   // one negotiation; result is {link, speed 100, full duplex}
   task automatic neg(input logic [7:0] ab, input logic [9:0] gp);
      logic [2:0] e;
      int n;
      e = expect_res(ab);
      p_ab = ab;
      p_gap = gp;
      restart(1'b1, 2'd1);
      n = 0;
      while (send !== 1'b1 && n < 2000)
      begin
         @(negedge clk);
         n++;
      end
      chk("holdoff", 16'h1, n >= HOLD - 2);
      wait_up(9000);
      chk("link_up", e[2], up);
      chk("link_led", !e[2], l_led);
      if (e[2])
      begin
         chk("speed", e[1], spd);
         chk("duplex", e[0], fd);
         chk("complete", 16'h1, ncomp);
         chk("partner_ab", ab, pcw[12:5]);
         chk("bursts", 16'h0, burst);
         chk("native", 16'h1, native);
         chk("speed_led", !e[1], s_led);
      end
      $display("test negotiate %h done", ab);
   endtask
   task automatic act(input logic r, input logic t, input logic x, input logic exp);
      rep = r;
      tx_act = t;
      rx_act = x;
      ticks(2);
      chk("act_led", exp, a_led);
   endtask
   // ************************
   // watchdog and main sequence
   // ************************
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         err_count++;
         $display("timeout at cycle %0d", cyc);
         tally_and_finish();
      end
   end
   initial
   begin
      ticks(10);
      rst_n = 1'b1;
      restart(1'b1, 2'd2);
      ticks(HOLD - 5);
      chk("refused", 16'h0, up);
      wait_up(2000);
      chk("par_up", 16'h1, up);
      chk("par_det", 16'h1, pdet);
      chk("neg_en", 16'h0, neg_en);
      chk("par_speed", 16'h0, spd);
      restart(1'b0, 2'd3);
      wait_up(2000);
      chk("par100", 16'h1, spd);
      restart(1'b0, 2'd1);
      ticks(3000);
      chk("no_neg", 16'h0, up);
      rst_n = 1'b0;
      ticks(2);
      chk("hw_reset", 16'h1, neg_en);
      chk("hw_led", 16'h1, l_led);
      rst_n = 1'b1;
      $display("test parallel done");
      neg(8'h2F, 10'd40);
      act(1'b0, 1'b1, 1'b0, 1'b0);
      act(1'b0, 1'b0, 1'b1, 1'b0);
      act(1'b1, 1'b1, 1'b0, 1'b1);
      act(1'b1, 1'b0, 1'b1, 1'b0);
      act(1'b0, 1'b0, 1'b0, 1'b1);
      // duplex first: forcing speed also forces the duplex setting
      dled = 1'b1;
      ticks(2);
      chk("dup_led", 16'h0, d_led);
      frc = 1'b1;
      ticks(2);
      chk("forced10", 16'h1, s_led);
      frc100 = 1'b1;
      ticks(2);
      chk("forced100", 16'h0, s_led);
      frc = 1'b0;
      link_ok = 1'b0;
      ticks(2);
      link_ok = 1'b1;
      ticks(3);
      chk("loss_up", 16'h0, up);
      chk("loss_led", 16'h1, l_led);
      chk("keep_speed", 16'h0, s_led);
      $display("test leds done");
      neg(8'h16, 10'd300);
      neg(8'h13, 10'd40);
      neg(8'h11, 10'd300);
      soft_rst = 1'b1;
      ticks(1);
      soft_rst = 1'b0;
      ticks(1);
      chk("soft_up", 16'h0, up);
      chk("soft_led", 16'h1, l_led);
      neg(8'h10, 10'd40);
      tally_and_finish();
   end
endmodule
